// [common/sli_pkg.sv]
// Purpose: constants and types for the status indicator and address strap block
// Assumes: 25 MHz clock, asynchronous active-low reset
// Notes: indicator pins double as address straps during reset
// Notes on behaviour
// - speed indicator high at 100, low at 10
// - tx indicator on while transmit activity present
// - rx indicator on while receive activity present
// - collision indicator shows half-duplex collision activity
// - duplex indicator reflects full-duplex operation
// - link indicator shows good link, both speeds
// - latch five address straps at hardware reset
// - strapped address spans zero to 31
// - strapped address zero selects MII isolate
// - software address zero never selects isolate
// - after reset strap pins drive indicators
// - line signalling follows forced or negotiated speed
package sli_pkg;
	localparam int ADDR_WIDTH = 5;
	localparam logic [4:0] ADDR_RESET = 5'h00;
	localparam logic [4:0] ISOLATE_ADDR = 5'h00;
	localparam int CLK_HZ = 25000000;
	localparam int STRETCH_MS = 50;
	localparam int STRETCH_CYCLES = CLK_HZ / 1000 * STRETCH_MS;
	localparam int STRAP_SETTLE_CYCLES = 2;
	typedef enum logic [2:0] {
		SLI_ST_RESET = 3'h1,
		SLI_ST_SAMPLE = 3'h2,
		SLI_ST_RUN = 3'h4
	} sli_phase_type;
endpackage

// [common/sli_stretch_if.sv]
`timescale 1ns/1ns
// Purpose: carries one event and its stretched indication
// Assumes: single clock domain
// Notes: none
interface sli_stretch_if;
	logic event_in;
	logic stretched;
	modport owner (output event_in, input stretched);
	modport stretcher (input event_in, output stretched);
endinterface

// [hdl/sli_stretch.sv]
`timescale 1ns/1ns
// Purpose: stretch a short event to a minimum visible on-time
// Assumes: event is synchronous to clk
// Notes: retriggerable, so steady activity keeps the indicator lit
module sli_stretch #(
	parameter int HOLD_CYCLES = 1250000
) (
	// clock and reset
	input  wire logic      clk,
	input  wire logic      rst_n,
	// event link
	sli_stretch_if.stretcher link
);
	import sli_pkg::*;
	typedef struct packed {
		logic [31:0] count;
		logic        lit;
	} sli_stretch_state_type;
	sli_stretch_state_type state;
	sli_stretch_state_type next_state;

	always_comb begin
		next_state = state;
		if (link.event_in) begin
			next_state.count = 32'(HOLD_CYCLES);
			next_state.lit = 1'b1;
		end else if (state.count > 32'h0) begin
			next_state.count = state.count - 32'h1;
			next_state.lit = 1'b1;
		end else begin
			next_state.lit = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign link.stretched = state.lit | link.event_in;
endmodule

// [hdl/sli_status.sv]
`timescale 1ns/1ns
// Purpose: status indicators, address strap latch, isolate select, speed select
// Assumes: status inputs come from logic on clk; strap pins are asynchronous
// Notes: strap pins are tristated during reset and a short settle after it
module sli_status #(
	parameter int STRETCH = sli_pkg::STRETCH_CYCLES
) (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// resolved link state from the core
	input  wire logic                          link_up,
	input  wire logic                          speed_100,
	input  wire logic                          full_duplex,
	input  wire logic                          tx_active,
	input  wire logic                          rx_active,
	input  wire logic                          collision,
	// management address written by software
	input  wire logic                          sw_addr_write,
	input  wire logic [sli_pkg::ADDR_WIDTH-1:0] sw_addr,
	// shared indicator and strap pins, bit 0 duplex .. bit 4 rx
	input  wire logic [4:0]                    strap_pin_in,
	output logic      [4:0]                    strap_pin_out,
	output logic      [4:0]                    strap_pin_oe,
	// dedicated speed indicator
	output logic                               speed_indicator,
	// results
	output logic      [sli_pkg::ADDR_WIDTH-1:0] mgmt_address,
	output logic                               mii_isolate,
	output logic                               line_sel_100
);
	import sli_pkg::*;

	typedef struct packed {
		sli_phase_type         phase;
		logic [4:0]            strap_meta;
		logic [4:0]            strap_sync;
		logic [1:0]            settle;
		logic [ADDR_WIDTH-1:0] addr;
		logic                  isolate;
		logic [5:0]            leds;
		logic                  sel_100;
	} sli_state_type;

	sli_state_type state;
	sli_state_type next_state;

	sli_stretch_if tx_link ();
	sli_stretch_if rx_link ();
	sli_stretch_if col_link ();

	// collision is only meaningful in half duplex
	assign tx_link.event_in = tx_active;
	assign rx_link.event_in = rx_active;
	assign col_link.event_in = collision & ~full_duplex;

	sli_stretch #(.HOLD_CYCLES(STRETCH)) u_tx (
		.clk   (clk),
		.rst_n (rst_n),
		.link  (tx_link.stretcher)
	);
	sli_stretch #(.HOLD_CYCLES(STRETCH)) u_rx (
		.clk   (clk),
		.rst_n (rst_n),
		.link  (rx_link.stretcher)
	);
	sli_stretch #(.HOLD_CYCLES(STRETCH)) u_col (
		.clk   (clk),
		.rst_n (rst_n),
		.link  (col_link.stretcher)
	);

	always_comb begin
		next_state = state;
		// two-stage synchroniser; only the second stage is read
		next_state.strap_meta = strap_pin_in;
		next_state.strap_sync = state.strap_meta;
		unique case (state.phase)
			SLI_ST_RESET: begin
				// pins still released so the sync chain sees the straps
				if (state.settle == 2'(STRAP_SETTLE_CYCLES)) begin
					next_state.phase = SLI_ST_SAMPLE;
				end else begin
					next_state.settle = state.settle + 2'h1;
				end
			end
			SLI_ST_SAMPLE: begin
				next_state.addr = state.strap_sync;
				next_state.isolate = (state.strap_sync == ISOLATE_ADDR);
				next_state.phase = SLI_ST_RUN;
			end
			SLI_ST_RUN: begin
				// isolate stays as strapped; software only moves the address
				if (sw_addr_write) begin
					next_state.addr = sw_addr;
				end
			end
			default: begin
				next_state.phase = SLI_ST_RESET;
			end
		endcase
		next_state.leds[0] = full_duplex;
		next_state.leds[1] = col_link.stretched;
		next_state.leds[2] = link_up;
		next_state.leds[3] = tx_link.stretched;
		next_state.leds[4] = rx_link.stretched;
		next_state.leds[5] = speed_100;
		next_state.sel_100 = speed_100;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '0;
			state.phase <= SLI_ST_RESET;
			state.addr <= ADDR_RESET;
		end else begin
			state <= next_state;
		end
	end

	// drive indicators only once the straps are captured
	assign strap_pin_out = state.leds[4:0];
	assign strap_pin_oe = (state.phase == SLI_ST_RUN) ? 5'h1F : 5'h00;
	assign speed_indicator = state.leds[5];
	assign mgmt_address = state.addr;
	assign mii_isolate = state.isolate;
	assign line_sel_100 = state.sel_100;
endmodule

// [bench/sli_status_asserts.sv]
// Purpose: port checks of sli_status
// Assumes: oe high marks the run phase
// Notes: rx stretch is judged by the bench only
`timescale 1ns/1ns
module sli_status_asserts (
	input wire logic       clk, rst_n, speed_100, full_duplex, link_up,
	input wire logic       tx_active, rx_active, collision, sw_addr_write,
	input wire logic       speed_indicator, mii_isolate, line_sel_100,
	input wire logic [4:0] strap_pin_out, strap_pin_oe);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire run = strap_pin_oe[0];
	sequence tx_off; run && $fell(tx_active); endsequence
	AST_SPD: assert property (
		run |=> {speed_indicator, line_sel_100} == {2{$past(speed_100)}})
		else $error("spd");
	AST_DPLX: assert property (
		run |=> strap_pin_out[0] == $past(full_duplex)) else $error("dx");
	AST_LINK: assert property (
		run |=> strap_pin_out[2] == $past(link_up)) else $error("lnk");
	AST_TX: assert property (
		run && tx_active |=> strap_pin_out[3]) else $error("tx");
	AST_RX: assert property (
		run && rx_active |=> strap_pin_out[4]) else $error("rx");
	AST_COL: assert property (
		run && collision && !full_duplex |=> strap_pin_out[1]) else $error("col");
	AST_SW: assert property (
		run && sw_addr_write |=> $stable(mii_isolate)) else $error("iso");
	AST_OE: assert property (
		|strap_pin_oe |-> strap_pin_oe == 5'h1F) else $error("oe");
	AST_HOLD: assert property (
		tx_off |-> strap_pin_out[3] [*3]) else $error("hold");
endmodule

// [bench/sli_board.sv]
// Purpose: board straps and leds on the shared pins
// Assumes: one 5k strap resistor on each pin
// Notes: a released pin settles to its strap level
`timescale 1ns/1ns
module sli_board (input wire logic [4:0] strap, strap_pin_out,
	strap_pin_oe, output logic [4:0] strap_pin_in);
	assign strap_pin_in = strap_pin_oe & strap_pin_out | ~strap_pin_oe & strap;
endmodule

// [bench/status_led_and_address_strap_tb_top.sv]
// Purpose: self-checking bench of sli_status
// Assumes: stretch cut to 4 cycles to keep the run short
// Notes: straps change only while reset is held
`timescale 1ns/1ns
module status_led_and_address_strap_tb_top;
	logic clk = 0, rst_n = 0, link_up = 0, speed_100 = 0, full_duplex = 0;
	logic tx_active = 0, rx_active = 0, collision = 0, sw_addr_write = 0;
	logic speed_indicator, mii_isolate, line_sel_100;
	logic [4:0] sw_addr = 0, strap = 0, strap_pin_in, strap_pin_out;
	logic [4:0] strap_pin_oe, mgmt_address;
	int fail_count = 0, comparisons = 0;
	always #20 clk = ~clk;
	sli_status #(.STRETCH(4)) i_dut (.*);
	sli_board i_board (.*);
	task tick(int n);
		repeat (n) @(posedge clk);
		#2;
	endtask
	task chk(string n, logic [4:0] s, e);
		comparisons++;
		if (s !== e) fail_count++;
		if (s !== e) $display("unexpected %s expected %h seen %h", n, e, s);
	endtask
	task give_verdict;
		if (fail_count == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task t_strap(logic [4:0] v);
		rst_n = 0;
		strap = v;
		tick(12);
		rst_n = 1;
		tick(8);
		chk("addr", mgmt_address, v);
		chk("iso", 5'(mii_isolate), 5'(v == 5'h00));
		chk("oe", strap_pin_oe, 5'h1F);
	endtask
	task t_status;
		for (int i = 0; i < 8; i++) begin
			{link_up, speed_100, full_duplex} = 3'(i);
			tick(2);
			chk("led", strap_pin_out & 5'h05, 5'(i & 5));
			chk("spd", 5'({speed_indicator, line_sel_100}), 5'({2{speed_100}}));
		end
		collision = 1;
		tick(2);
		chk("col", strap_pin_out, 5'h05);
		collision = 0;
		tick(8);
	endtask
	task automatic t_act(ref logic ev, input int p);
		ev = 1;
		tick(1);
		chk("on", 5'(strap_pin_out[p]), 5'h01);
		ev = 0;
		tick(4 + 4);
		chk("off", 5'(strap_pin_out[p]), 5'h00);
	endtask
	task t_sw;
		sw_addr_write = 1;
		tick(1);
		sw_addr_write = 0;
		chk("sw", mgmt_address | 5'(mii_isolate), 5'h00);
	endtask
	initial begin
		t_strap(5'h00);
		t_strap(5'h1F);
		t_status();
		full_duplex = 0;
		t_act(tx_active, 3);
		t_act(rx_active, 4);
		t_act(collision, 1);
		t_sw();
		give_verdict();
	end
endmodule
bind sli_status sli_status_asserts u_chk (.*);
